// ==== core/alir_level_dec.sv ====
// module: registered decoder of one line-input level field
module alir_level_dec #(
  parameter int unsigned CODE_W = 4
) (
  input  wire logic                clock_in,
  input  wire logic                resetn_in,
  input  wire logic [CODE_W-1:0]   code_in,
  output alir_pkg::alir_lvl_t      level_out
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (CODE_W != 4)
  begin : g_chk
    $error("alir_level_dec serves only a 4-bit level field");
  end

  alir_pkg::alir_lvl_t st_q;
  alir_pkg::alir_lvl_t st_d;

  // reserved codes fall back to disconnected, the safe analog state
  always_comb
  begin
    st_d.conn  = 1'b0;
    st_d.atten = 5'h00;
    if (code_in <= alir_pkg::ALIR_LVL_MAX)
    begin
      st_d.conn  = 1'b1;
      st_d.atten = 5'({1'b0, code_in} * alir_pkg::ALIR_LVL_STEP);
    end
  end

  // state register
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign level_out = st_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_level_gain_map : assert property (@(posedge clock_in) disable iff (!resetn_in)
    code_in <= alir_pkg::ALIR_LVL_MAX |=>
      level_out.conn && level_out.atten == 5'($past(code_in) * 3))
    else $error("level code did not map to its attenuation");
  a_level_off_code : assert property (@(posedge clock_in) disable iff (!resetn_in)
    code_in == alir_pkg::ALIR_LVL_OFF |=> !level_out.conn)
    else $error("off code left the input connected");

endmodule : alir_level_dec

// ==== core/alir_regs.sv ====
// module: apb register bank for left adc line-input routing and gain stage
//
// Chosen here: register access over APB.
module alir_regs #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned GAIN_W = 7
) (
  input  wire logic                clock_in,
  input  wire logic                resetn_in,
  input  wire logic                apb_psel_in,
  input  wire logic                apb_penable_in,
  input  wire logic                apb_pwrite_in,
  input  wire logic [ADDR_W-1:0]   apb_paddr_in,
  input  wire logic [31:0]         apb_pwdata_in,
  input  wire logic [3:0]          apb_pstrb_in,
  output logic [31:0]              apb_prdata_out,
  output logic                     apb_pready_out,
  output logic                     apb_pslverr_out,
  input  wire logic                sample_rate_tick_in,
  output alir_pkg::alir_route_t    route_out,
  output alir_pkg::alir_gain_t     gain_out
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W != 12 || GAIN_W != 7)
  begin : g_chk
    $error("alir_regs serves a 12-bit address and a 7-bit gain only");
  end

  alir_pkg::alir_state_t st_q;
  alir_pkg::alir_state_t st_d;
  alir_pkg::alir_lvl_t   lvl1;
  alir_pkg::alir_lvl_t   lvl2;
  logic                  setup;
  logic                  access;
  logic                  hit;
  logic [7:0]            rd_byte;
  logic [6:0]            target;
  logic                  step_now;
  logic [1:0]            ss_mode;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------

  // zero wait states: every access finishes in its first access cycle
  assign setup          = apb_psel_in && !apb_penable_in;
  assign access         = apb_psel_in && apb_penable_in;
  assign apb_pready_out = 1'b1;
  assign ss_mode        = st_q.line1[alir_pkg::ALIR_SS_HI:alir_pkg::ALIR_SS_LO];

  // read mux, looked up in the setup cycle and held in a flop
  always_comb
  begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (apb_paddr_in)
      alir_pkg::ALIR_ADDR_GAIN:   rd_byte = st_q.gain_reg;
      alir_pkg::ALIR_ADDR_LINE1:  rd_byte = st_q.line1;
      alir_pkg::ALIR_ADDR_LINE2:  rd_byte = st_q.line2;
      alir_pkg::ALIR_ADDR_STATUS: rd_byte = {st_q.applied, st_q.phase};
      default:                    hit     = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // gain soft-stepping
  // ----------------------------------------------------------------

  // codes above the top value behave as the top value
  assign target = (st_q.gain_reg[6:0] > alir_pkg::ALIR_GAIN_SAT) ?
                  alir_pkg::ALIR_GAIN_SAT : st_q.gain_reg[6:0];

  // once per sample, or on every second sample using the phase flop
  always_comb
  begin
    case (ss_mode)
      alir_pkg::ALIR_SS_EVERY:  step_now = sample_rate_tick_in;
      alir_pkg::ALIR_SS_EVERY2: step_now = sample_rate_tick_in && st_q.phase;
      default:                  step_now = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    if (setup)
    begin
      st_d.rdata  = {24'h00_0000, rd_byte};
      st_d.slverr = !hit;
    end
    // writes land only on the completing access edge, byte lane 0
    if (access && apb_pwrite_in && apb_pstrb_in[0])
    begin
      case (apb_paddr_in)
        alir_pkg::ALIR_ADDR_GAIN:
          st_d.gain_reg = apb_pwdata_in[7:0];
        alir_pkg::ALIR_ADDR_LINE1:
          st_d.line1 = apb_pwdata_in[7:0];
        alir_pkg::ALIR_ADDR_LINE2:
          st_d.line2 = apb_pwdata_in[7:0] & alir_pkg::ALIR_LINE2_WMSK;
        default:
          st_d.line1 = st_q.line1;
      endcase
    end
    // phase only advances in the every-two mode
    if (ss_mode == alir_pkg::ALIR_SS_EVERY2)
    begin
      if (sample_rate_tick_in)
        st_d.phase = !st_q.phase;
    end
    else
      st_d.phase = 1'b0;
    // disabled stepping jumps straight to the target
    if (ss_mode[1])
      st_d.applied = target;
    else if (step_now && st_q.applied < target)
      st_d.applied = st_q.applied + 7'h01;
    else if (step_now && st_q.applied > target)
      st_d.applied = st_q.applied - 7'h01;
  end

  // state register
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
      st_q <= alir_pkg::ALIR_STATE_RST;
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // level decoders
  // ----------------------------------------------------------------
  alir_level_dec #(
    .CODE_W    (4)
  ) u_line1_dec (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .code_in   (st_q.line1[alir_pkg::ALIR_LVL_HI:alir_pkg::ALIR_LVL_LO]),
    .level_out (lvl1)
  );

  alir_level_dec #(
    .CODE_W    (4)
  ) u_line2_dec (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .code_in   (st_q.line2[alir_pkg::ALIR_LVL_HI:alir_pkg::ALIR_LVL_LO]),
    .level_out (lvl2)
  );

  // ----------------------------------------------------------------
  // outputs from flops, except pslverr, which is gated by the live access cycle
  // ----------------------------------------------------------------
  assign route_out.line1_diff = st_q.line1[alir_pkg::ALIR_DIFF_BIT];
  assign route_out.line1      = lvl1;
  assign route_out.line2_diff = st_q.line2[alir_pkg::ALIR_DIFF_BIT];
  assign route_out.line2      = lvl2;
  assign route_out.adc_power  = st_q.line1[alir_pkg::ALIR_PWR_BIT];
  assign route_out.cm_bias    = st_q.line2[alir_pkg::ALIR_BIAS_BIT];
  assign gain_out.gain        = st_q.applied;
  assign gain_out.mute        = st_q.gain_reg[alir_pkg::ALIR_MUTE_BIT];
  assign gain_out.stepping    = st_q.applied != target;
  assign apb_prdata_out       = st_q.rdata;
  assign apb_pslverr_out      = access && st_q.slverr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_wr_line1;
    access && apb_pwrite_in && apb_pstrb_in[0] && apb_paddr_in == alir_pkg::ALIR_ADDR_LINE1;
  endsequence

  sequence s_wr_line2;
    access && apb_pwrite_in && apb_pstrb_in[0] && apb_paddr_in == alir_pkg::ALIR_ADDR_LINE2;
  endsequence

  sequence s_rd_line2;
    setup && !apb_pwrite_in && apb_paddr_in == alir_pkg::ALIR_ADDR_LINE2 ##1 access;
  endsequence

  sequence s_rd_line1;
    setup && !apb_pwrite_in && apb_paddr_in == alir_pkg::ALIR_ADDR_LINE1 ##1 access;
  endsequence

  sequence s_wr_gain;
    access && apb_pwrite_in && apb_pstrb_in[0] && apb_paddr_in == alir_pkg::ALIR_ADDR_GAIN;
  endsequence

  // an unmapped setup cycle followed by its access cycle
  sequence s_rd_miss;
    setup && !hit ##1 access;
  endsequence

  a_line1_store : assert property (s_wr_line1 |=>
    st_q.line1 == $past(apb_pwdata_in[7:0]))
    else $error("line1 register did not store the written byte");

  a_line1_mode : assert property (s_wr_line1 |=>
    route_out.line1_diff == $past(apb_pwdata_in[7]))
    else $error("first input mode not taken from bit 7");

  a_adc_power : assert property (s_wr_line1 |=>
    route_out.adc_power == $past(apb_pwdata_in[2]))
    else $error("adc power not taken from bit 2");

  // level outputs trail the register by one flop, hence the extra cycle
  a_line1_level : assert property (s_wr_line1 ##1 1'b1 |=>
    route_out.line1.conn == ($past(apb_pwdata_in[6:3], 2) <= 4'h8))
    else $error("first input connection does not follow its level code");

  a_line2_mode : assert property (s_wr_line2 |=>
    route_out.line2_diff == $past(apb_pwdata_in[7])
    && route_out.cm_bias == $past(apb_pwdata_in[2]))
    else $error("second register mode or bias not stored");

  a_line2_level : assert property (s_wr_line2 ##1 1'b1 |=>
    route_out.line2.conn == ($past(apb_pwdata_in[6:3], 2) <= 4'h8))
    else $error("second input connection does not follow its level code");

  a_rsvd_read : assert property (s_rd_line2 |->
    apb_prdata_out[1:0] == 2'h0 && apb_prdata_out[31:8] == 24'h00_0000)
    else $error("reserved bits did not read as zero");

  a_rsvd_store : assert property (st_q.line2[1:0] == 2'h0)
    else $error("reserved bits of the second register hold a one");

  a_line1_read : assert property (s_rd_line1 |->
    apb_prdata_out == {24'h00_0000, $past(st_q.line1)})
    else $error("line1 read did not return the stored byte");

  a_miss_error : assert property (s_rd_miss |->
    apb_pslverr_out && apb_prdata_out == 32'h0000_0000)
    else $error("unmapped access did not answer with an error");

  a_gain_store : assert property (s_wr_gain |=>
    st_q.gain_reg == $past(apb_pwdata_in[7:0]) && gain_out.mute == $past(apb_pwdata_in[7]))
    else $error("gain register or mute bit not stored");

  a_gain_clamp : assert property (st_q.gain_reg[6:0] >= 7'h77 |-> target == 7'h77)
    else $error("gain target not clamped at the top value");

  a_soft_off : assert property (ss_mode[1] |=> st_q.applied == $past(target))
    else $error("disabled soft-stepping did not jump to target");

  a_soft_one_step : assert property (ss_mode == 2'h0 && sample_rate_tick_in
    && st_q.applied != target && !access |=>
    (st_q.applied == $past(st_q.applied) + 7'h01)
    || (st_q.applied == $past(st_q.applied) - 7'h01))
    else $error("soft-step did not move by exactly one step");

  // every-two mode: the first tick of a pair only flips the phase
  a_soft_two_wait : assert property (ss_mode == 2'h1 && sample_rate_tick_in
    && !st_q.phase |=> st_q.phase && st_q.applied == $past(st_q.applied))
    else $error("every-two stepping moved on the first tick of a pair");

  a_soft_two_step : assert property (ss_mode == 2'h1 && sample_rate_tick_in
    && st_q.phase && st_q.applied != target |=> !st_q.phase
    && (st_q.applied == $past(st_q.applied) + 7'h01
    || st_q.applied == $past(st_q.applied) - 7'h01))
    else $error("every-two stepping did not step on the second tick");

  a_phase_clear : assert property (ss_mode != 2'h1 |=> !st_q.phase)
    else $error("stepping phase not cleared outside the every-two mode");

  a_soft_hold : assert property (!ss_mode[1] && !step_now |=>
    st_q.applied == $past(st_q.applied))
    else $error("gain moved without a step enable");

  a_gain_sat : assert property (st_q.applied <= 7'h77)
    else $error("applied gain above the saturation value");

  a_mute_reset : assert property (@(posedge clock_in) disable iff (1'b0)
    !resetn_in |=> gain_out.mute && !route_out.line1.conn)
    else $error("reset did not mute the gain stage");

  a_reset_route : assert property (@(posedge clock_in) disable iff (1'b0)
    !resetn_in |=> !route_out.adc_power && !route_out.line2.conn
    && !route_out.line1_diff && gain_out.gain == 7'h00)
    else $error("reset did not clear routing and applied gain");

endmodule : alir_regs

// ==== include/alir_pkg.sv ====
// package: constants and types for the left adc line-input routing registers
package alir_pkg;

  // ----------------------------------------------------------------
  // register indexes and byte addresses (index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ALIR_IDX_GAIN   = 8'h0f;
  localparam logic [7:0]  ALIR_IDX_LINE1  = 8'h13;
  localparam logic [7:0]  ALIR_IDX_LINE2  = 8'h14;
  localparam logic [7:0]  ALIR_IDX_STATUS = 8'h30;
  localparam logic [11:0] ALIR_ADDR_GAIN   = {2'h0, ALIR_IDX_GAIN, 2'h0};
  localparam logic [11:0] ALIR_ADDR_LINE1  = {2'h0, ALIR_IDX_LINE1, 2'h0};
  localparam logic [11:0] ALIR_ADDR_LINE2  = {2'h0, ALIR_IDX_LINE2, 2'h0};
  localparam logic [11:0] ALIR_ADDR_STATUS = {2'h0, ALIR_IDX_STATUS, 2'h0};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned ALIR_DIFF_BIT = 7;
  localparam int unsigned ALIR_LVL_HI   = 6;
  localparam int unsigned ALIR_LVL_LO   = 3;
  localparam int unsigned ALIR_PWR_BIT  = 2;
  localparam int unsigned ALIR_BIAS_BIT = 2;
  localparam int unsigned ALIR_SS_HI    = 1;
  localparam int unsigned ALIR_SS_LO    = 0;
  localparam int unsigned ALIR_MUTE_BIT = 7;

  // ----------------------------------------------------------------
  // reset values, masks and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ALIR_LINE1_RST  = 8'h78;
  localparam logic [7:0] ALIR_LINE2_RST  = 8'h78;
  localparam logic [7:0] ALIR_GAIN_RST   = 8'h80;
  localparam logic [7:0] ALIR_LINE2_WMSK = 8'hfc;
  localparam logic [3:0] ALIR_LVL_MAX    = 4'h8;
  localparam logic [3:0] ALIR_LVL_OFF    = 4'hf;
  localparam logic [4:0] ALIR_LVL_STEP   = 5'h03;
  localparam logic [6:0] ALIR_GAIN_SAT   = 7'h77;
  localparam logic [1:0] ALIR_SS_EVERY   = 2'h0;
  localparam logic [1:0] ALIR_SS_EVERY2  = 2'h1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       conn;
    logic [4:0] atten;
  } alir_lvl_t;

  typedef struct packed {
    logic      line1_diff;
    alir_lvl_t line1;
    logic      line2_diff;
    alir_lvl_t line2;
    logic      adc_power;
    logic      cm_bias;
  } alir_route_t;

  typedef struct packed {
    logic [6:0] gain;
    logic       mute;
    logic       stepping;
  } alir_gain_t;

  typedef struct packed {
    logic [7:0]  line1;
    logic [7:0]  line2;
    logic [7:0]  gain_reg;
    logic [6:0]  applied;
    logic        phase;
    logic [31:0] rdata;
    logic        slverr;
  } alir_state_t;

  localparam alir_state_t ALIR_STATE_RST = '{
    line1: ALIR_LINE1_RST, line2: ALIR_LINE2_RST, gain_reg: ALIR_GAIN_RST,
    applied: 7'h00, phase: 1'b0, rdata: 32'h0000_0000, slverr: 1'b0};

endpackage : alir_pkg

// ==== verification/alir_host_model.sv ====
// host software model: apb master issuing one register transfer at a time
module alir_host_model (
  input  wire logic        clock_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [11:0]      paddr_out,
  output logic [31:0]      pwdata_out,
  output logic [3:0]       pstrb_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // byte strobes of the next transfer; the bench may clear lane 0
  logic [3:0] strobe;

  // ----------------------------------------------------------------
  // idle bus at time zero
  // ----------------------------------------------------------------
  initial
  begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
    pstrb_out = 4'hf;
    strobe = 4'hf;
  end

  // one transfer; data is passed as given, so level codes and reserved
  // bits are up to the caller, which may set reserved bits on purpose
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clock_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    pstrb_out <= strobe;
    @(posedge clock_in);
    penable_out <= 1'b1;
    @(posedge clock_in);
    // no wait-state count is assumed; the bench timeout ends a hang
    while (pready_in !== 1'b1)
    begin
      @(posedge clock_in);
    end
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask : xfer
endmodule : alir_host_model

// ==== verification/alir_regs_tb.sv ====
// testbench: self-checking sequences for the left adc routing registers
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module alir_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] L1 = alir_pkg::ALIR_ADDR_LINE1;
  localparam logic [11:0] L2 = alir_pkg::ALIR_ADDR_LINE2;
  localparam logic [11:0] GN = alir_pkg::ALIR_ADDR_GAIN;
  localparam logic [11:0] ST = alir_pkg::ALIR_ADDR_STATUS;

  logic                  clock_in = 1'b0;
  logic                  resetn_in = 1'b0;
  logic                  tick = 1'b0;
  logic                  psel, penable, pwrite, pready, pslverr;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata;
  logic [3:0]            pstrb;
  alir_pkg::alir_route_t route;
  alir_pkg::alir_gain_t  gain;
  int                    miscompares = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  logic [31:0]           rdv;
  logic                  err;
  logic [3:0]            lv;

  always #50 clock_in = ~clock_in;

  alir_regs uut (.clock_in(clock_in), .resetn_in(resetn_in), .apb_psel_in(psel),
    .apb_penable_in(penable), .apb_pwrite_in(pwrite), .apb_paddr_in(paddr),
    .apb_pwdata_in(pwdata), .apb_pstrb_in(pstrb), .apb_prdata_out(prdata),
    .apb_pready_out(pready), .apb_pslverr_out(pslverr), .sample_rate_tick_in(tick),
    .route_out(route), .gain_out(gain));

  alir_host_model host (.clock_in(clock_in), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb));

  // ----------------------------------------------------------------
  // closing report and hang guard
  // ----------------------------------------------------------------
  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // the whole run needs well under a thousand cycles
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, rdv, err);
    `CHK(err, 1'b0)
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 32'h0, rdv, err);
    `CHK(rdv, {24'h0, e})
    `CHK(err, 1'b0)
  endtask : rd

  // level decode lags the register by one flop, so three edges suffice
  task automatic settle();
    repeat (3) @(posedge clock_in);
    #1;
  endtask : settle

  // one sample-period pulse, seen by the design at the second edge
  task automatic pulse();
    @(posedge clock_in);
    tick <= 1'b1;
    @(posedge clock_in);
    tick <= 1'b0;
    #1;
  endtask : pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd(L1, 8'h78);
    rd(L2, 8'h78);
    `CHK(route, '0)
    `CHK(gain.mute, 1'b1)
    // only codes 0..8 and 15 are written
    for (int c = 0; c <= 8; c++)
    begin
      lv = 4'(c);
      wr(L1, {1'b1, lv, 1'b1, 2'h3});
      rd(L1, {1'b1, lv, 1'b1, 2'h3});
      // reserved low bits written as ones on purpose to see them dropped
      wr(L2, {1'b1, lv, 1'b1, 2'h3});
      rd(L2, {1'b1, lv, 1'b1, 2'h0});
      settle();
      `CHK(route.line1.conn, 1'b1)
      `CHK(route.line1.atten, 5'(c * 3))
      `CHK(route.line1_diff, 1'b1)
      `CHK(route.adc_power, 1'b1)
      `CHK(route.line2.conn, 1'b1)
      `CHK(route.line2.atten, 5'(c * 3))
      `CHK(route.line2_diff, 1'b1)
      `CHK(route.cm_bias, 1'b1)
    end
    wr(L1, 8'h7b);
    wr(L2, 8'h78);
    settle();
    `CHK(route.line1.conn, 1'b0)
    `CHK(route.line2.conn, 1'b0)
    `CHK({route.line1_diff, route.adc_power, route.cm_bias}, 3'h0)
    // unmapped word answers with an error and zero data
    host.xfer(1'b0, 12'h004, 32'h0, rdv, err);
    `CHK(err, 1'b1)
    `CHK(rdv, 32'h0)
    // stepping disabled: applied gain jumps straight to target
    wr(GN, 8'h05);
    settle();
    `CHK(gain.gain, 7'h05)
    `CHK(gain.mute, 1'b0)
    // once per sample period
    wr(L1, 8'h78);
    wr(GN, 8'h07);
    pulse();
    `CHK(gain.gain, 7'h06)
    `CHK(gain.stepping, 1'b1)
    pulse();
    `CHK(gain.gain, 7'h07)
    `CHK(gain.stepping, 1'b0)
    // once per two sample periods
    wr(L1, 8'h79);
    wr(GN, 8'h05);
    pulse();
    `CHK(gain.gain, 7'h07)
    pulse();
    `CHK(gain.gain, 7'h06)
    // status shows applied gain and phase; writes to it are dropped
    wr(ST, 8'hff);
    rd(ST, 8'h0c);
    // saturation above the top code, mute set again
    wr(L1, 8'h7a);
    wr(GN, 8'hff);
    settle();
    `CHK(gain.gain, 7'h77)
    `CHK(gain.mute, 1'b1)
    // mid-run reset puts every field back to its reset value
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    #1;
    `CHK(route, '0)
    `CHK(gain, 9'h002)
    rd(L1, 8'h78);
    rd(GN, 8'h80);
    // a write with its low byte strobe off leaves the register alone
    host.strobe = 4'he;
    wr(L1, 8'h87);
    host.strobe = 4'hf;
    rd(L1, 8'h78);
    test_done();
  end
endmodule : alir_regs_tb
